/* File: hw/adsc_ctrl.sv */
// Sequencer control, global control register and instruction memory
`timescale 1ns/10ps
module adsc_ctrl #(
	parameter int unsigned FULL_CAL_CYCLES = adsc_pkg::FULL_CAL_CYC,
	parameter int unsigned SETTLE_CYCLES = adsc_pkg::SETTLE_CYC,
	parameter int unsigned NUM_INSTR = 8
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Parallel host bus
	input wire adsc_pkg::adsc_bus_req_t bus_req_in,
	input wire logic bus_width_select_in,
	output logic [15:0] bus_rdata_out,
	// Analog converter
	output adsc_pkg::adsc_adc_ctl_t adc_ctl_out,
	input wire logic adc_done_in,
	input wire logic [12:0] adc_result_in,
	// Conversion FIFO write side
	output logic fifo_wr_out,
	output logic [15:0] fifo_data_out,
	output logic fifo_clear_out,
	// Sync pin
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe_n_out,
	// Power control and event flags
	output logic clk_gate_out,
	output logic [7:0] flags_out
);

	localparam int unsigned W = adsc_pkg::CNT_W;

	////////////////////////////////////////////////////////////////////////////////
	// Storage and state

	logic [15:0] instr_mem [NUM_INSTR][3];
	logic run, stop_pend, reset_bit, short_req, full_req, standby;
	logic chan_mask, az_each, sync_dir, test_bit, self_verify_mode_bit;
	logic [1:0] sec_ptr, rst_cnt;
	logic [2:0] ptr;
	logic [7:0] flags;
	logic sync_prev;
	logic signed [8:0] wd_sample;
	adsc_pkg::adsc_state_t state, next_state;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire logic [3:0] waddr = bus_req_in.addr[4:1];
	wire logic lo_lane = !bus_width_select_in || !bus_req_in.addr[0];
	wire logic hi_lane = !bus_width_select_in || bus_req_in.addr[0];
	wire logic wr_hit = bus_req_in.cs && bus_req_in.wr;
	wire logic rd_hit = bus_req_in.cs && bus_req_in.rd;
	wire logic ram_hit = !waddr[3];
	wire logic [2:0] ram_idx = waddr[2:0];
	wire logic sec_ok = (sec_ptr != adsc_pkg::SEC_RESERVED);
	wire logic ctrl_wr = wr_hit && (waddr == adsc_pkg::CTRL_WADDR);
	wire logic ctrl_cmd = ctrl_wr && lo_lane;
	wire logic stat_rd = rd_hit && (waddr == adsc_pkg::STAT_WADDR) && lo_lane;
	wire logic [15:0] ctrl_word = {4'h0, self_verify_mode_bit, test_bit, sec_ptr, sync_dir, az_each,
		chan_mask, standby, full_req, short_req, reset_bit, run};
	wire logic [15:0] stat_word = {5'h00, ptr, flags};
	wire logic [15:0] ram_word = sec_ok ? instr_mem[ram_idx][sec_ptr] : 16'h0000;
	wire logic [15:0] cur_word = ram_hit ? ram_word :
		(waddr == adsc_pkg::CTRL_WADDR) ? ctrl_word :
		(waddr == adsc_pkg::STAT_WADDR) ? stat_word : 16'h0000;
	// Byte writes merge into the stored word so the other lane keeps its value
	wire logic [15:0] wval = {hi_lane ? (bus_width_select_in ? bus_req_in.wdata[7:0]
		: bus_req_in.wdata[15:8]) : cur_word[15:8],
		lo_lane ? bus_req_in.wdata[7:0] : cur_word[7:0]};
	wire logic [15:0] next_rdata = !bus_width_select_in ? cur_word :
		bus_req_in.addr[0] ? {8'h00, cur_word[15:8]} : {8'h00, cur_word[7:0]};

	////////////////////////////////////////////////////////////////////////////////
	// Instruction fields and derived values

	wire logic [15:0] ins0 = instr_mem[ptr][0];
	wire logic [15:0] lim1 = instr_mem[ptr][1];
	wire logic [15:0] lim2 = instr_mem[ptr][2];
	wire logic ins_wdog = ins0[adsc_pkg::INS_WDOG];
	wire logic ins_short = ins0[adsc_pkg::INS_RES8] || ins_wdog;
	wire logic [3:0] acq_d = ins0[adsc_pkg::INS_ACQ_LO +: 4];
	wire logic [W-1:0] acq_cycles = W'(ins_short ? adsc_pkg::ACQ_BASE_8 : adsc_pkg::ACQ_BASE_12)
		+ W'({acq_d, 1'b0});
	wire logic self_verify_mode_on = self_verify_mode_bit && !test_bit;
	wire logic sync_rise = !sync_dir && sync_in && !sync_prev;
	wire logic need_sync = !sync_dir && ins0[adsc_pkg::INS_SYNC];
	wire logic conv_active = (state == adsc_pkg::S_ACQ) || (state == adsc_pkg::S_CONV) ||
		(state == adsc_pkg::S_WD1) || (state == adsc_pkg::S_WD2);
	wire logic hit1;
	wire logic hit2;
	wire logic cnt_done;
	wire logic settle_done;
	logic cnt_load;
	logic [W-1:0] cnt_value;
	logic instr_end;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer next state; calibrations wait in idle so they follow the instruction

	always_comb begin
		next_state = state;
		cnt_load = 1'b0;
		cnt_value = '0;
		instr_end = 1'b0;
		case (state)
			adsc_pkg::S_IDLE: begin
				if (standby || reset_bit) begin
					next_state = adsc_pkg::S_IDLE;
				end else if (short_req) begin
					next_state = adsc_pkg::S_CAL_SHORT;
					cnt_load = 1'b1;
					cnt_value = W'(adsc_pkg::SHORT_CAL_CYC);
				end else if (full_req) begin
					next_state = adsc_pkg::S_CAL_FULL;
					cnt_load = 1'b1;
					cnt_value = W'(FULL_CAL_CYCLES);
				end else if (run) begin
					next_state = adsc_pkg::S_FETCH;
				end
			end
			adsc_pkg::S_FETCH: begin
				if (ins0[adsc_pkg::INS_PAUSE]) begin
					next_state = adsc_pkg::S_IDLE;
					instr_end = 1'b1;
				end else if (az_each) begin
					next_state = adsc_pkg::S_AZ;
					cnt_load = 1'b1;
					cnt_value = W'(adsc_pkg::SHORT_CAL_CYC);
				end else if (need_sync) begin
					next_state = adsc_pkg::S_SYNC;
				end else begin
					next_state = adsc_pkg::S_ACQ;
					cnt_load = 1'b1;
					cnt_value = acq_cycles;
				end
			end
			adsc_pkg::S_AZ: begin
				if (cnt_done) begin
					next_state = need_sync ? adsc_pkg::S_SYNC : adsc_pkg::S_ACQ;
					cnt_load = !need_sync;
					cnt_value = acq_cycles;
				end
			end
			adsc_pkg::S_SYNC: begin
				if (sync_rise) begin
					next_state = adsc_pkg::S_ACQ;
					cnt_load = 1'b1;
					cnt_value = acq_cycles;
				end
			end
			adsc_pkg::S_ACQ: begin
				if (cnt_done) begin
					next_state = adsc_pkg::S_CONV;
				end
			end
			adsc_pkg::S_CONV: begin
				if (adc_done_in) begin
					next_state = ins_wdog ? adsc_pkg::S_WD1 : adsc_pkg::S_IDLE;
					instr_end = !ins_wdog;
				end
			end
			adsc_pkg::S_WD1: begin
				next_state = adsc_pkg::S_WD2;
			end
			adsc_pkg::S_WD2: begin
				next_state = adsc_pkg::S_IDLE;
				instr_end = 1'b1;
			end
			adsc_pkg::S_CAL_SHORT, adsc_pkg::S_CAL_FULL: begin
				if (cnt_done) begin
					next_state = adsc_pkg::S_IDLE;
				end
			end
			default: begin
				next_state = adsc_pkg::S_IDLE;
			end
		endcase
	end

	// Shared interval timer for acquisition, auto-zero and calibration
	adsc_down_count #(.W(W)) u_seq_cnt (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.load_in(cnt_load),
		.value_in(cnt_value),
		.busy_out(),
		.done_out(cnt_done)
	);

	// Analog settling after standby release; a separate timer keeps the sequencer free
	adsc_down_count #(.W(W)) u_settle_cnt (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.load_in(ctrl_cmd && standby && !wval[adsc_pkg::CFG_STANDBY]),
		.value_in(W'(SETTLE_CYCLES)),
		.busy_out(),
		.done_out(settle_done)
	);

	adsc_limit_cmp u_cmp1 (
		.sample_in(wd_sample),
		.section_in(lim1),
		.hit_out(hit1)
	);

	adsc_limit_cmp u_cmp2 (
		.sample_in(wd_sample),
		.section_in(lim2),
		.hit_out(hit2)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Instruction memory; writable in standby as well

	for (genvar i = 0; i < NUM_INSTR; i++) begin : g_mem
		for (genvar s = 0; s < 3; s++) begin : g_sec
			wire logic we = wr_hit && ram_hit && (ram_idx == 3'(i)) && (sec_ptr == 2'(s));
			always_ff @(posedge sys_clk_in or posedge rst_in) begin
				if (rst_in) begin
					instr_mem[i][s] <= 16'h0000;
				end else if (we) begin
					instr_mem[i][s] <= wval;
				end
			end
		end
	end

	// Sequencer state; reset bit forces idle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= adsc_pkg::S_IDLE;
		end else begin
			state <= reset_bit ? adsc_pkg::S_IDLE : next_state;
		end
	end

	// Reset bit: raised at power-up, on command, and held through standby
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reset_bit <= 1'b1;
			rst_cnt <= adsc_pkg::RESET_HOLD_CYC;
		end else if (ctrl_cmd && (wval[adsc_pkg::CFG_RESET] || wval[adsc_pkg::CFG_STANDBY]
				|| standby)) begin
			reset_bit <= 1'b1;
			rst_cnt <= adsc_pkg::RESET_HOLD_CYC;
		end else if (reset_bit && !standby) begin
			reset_bit <= (rst_cnt != 2'h1);
			rst_cnt <= rst_cnt - 2'h1;
		end
	end

	// Control bits other than the commands
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{standby, chan_mask, az_each, sync_dir} <= 4'h0;
			{sec_ptr, test_bit, self_verify_mode_bit} <= 4'h0;
		end else if (ctrl_wr) begin
			if (lo_lane) begin
				standby <= wval[adsc_pkg::CFG_STANDBY];
				chan_mask <= wval[adsc_pkg::CFG_CHAN_MASK];
				az_each <= wval[adsc_pkg::CFG_AZ_EACH];
				sync_dir <= wval[adsc_pkg::CFG_SYNC_OUT];
			end
			if (hi_lane) begin
				sec_ptr <= wval[adsc_pkg::CFG_SEC_LO +: 2];
				test_bit <= wval[adsc_pkg::CFG_TEST];
				self_verify_mode_bit <= wval[adsc_pkg::CFG_SELF_VERIFY_MODE];
			end
		end
	end

	// Run, stop request and calibration requests
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{run, stop_pend, short_req, full_req} <= 4'h0;
		end else if (reset_bit) begin
			{run, stop_pend} <= 2'h0;
		end else begin
			if (ctrl_cmd) begin
				run <= wval[adsc_pkg::CFG_START] || (run && state != adsc_pkg::S_IDLE);
				stop_pend <= !wval[adsc_pkg::CFG_START];
			end else if (instr_end && (stop_pend || ins0[adsc_pkg::INS_PAUSE])) begin
				{run, stop_pend} <= 2'h0;
			end
			short_req <= (ctrl_cmd && wval[adsc_pkg::CFG_SHORT_CAL]) ||
				(short_req && !(state == adsc_pkg::S_CAL_SHORT && cnt_done));
			full_req <= (ctrl_cmd && wval[adsc_pkg::CFG_FULL_CAL]) ||
				(full_req && !(state == adsc_pkg::S_CAL_FULL && cnt_done));
		end
	end

	// Instruction pointer: loop bit wraps to the first instruction
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ptr <= 3'h0;
		end else if (reset_bit) begin
			ptr <= 3'h0;
		end else if (instr_end) begin
			ptr <= ins0[adsc_pkg::INS_LOOP] ? 3'h0 : ptr + 3'h1;
		end
	end

	// Event flags; a new event beats a clearing read in the same cycle
	wire logic [7:0] flag_set = {settle_done, 1'b0,
		(state == adsc_pkg::S_FETCH) && ins0[adsc_pkg::INS_PAUSE],
		(state == adsc_pkg::S_CAL_FULL) && cnt_done,
		(state == adsc_pkg::S_CAL_SHORT) && cnt_done, 2'h0,
		((state == adsc_pkg::S_WD1) && hit1) || ((state == adsc_pkg::S_WD2) && hit2)};
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags <= 8'h00;
		end else if (reset_bit) begin
			flags <= {flag_set[adsc_pkg::ST_STANDBY], 7'h00};
		end else begin
			flags <= flag_set | (stat_rd ? 8'h00 : flags);
		end
	end

	// Outputs that come from flip-flops
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_rdata_out <= 16'h0000;
			fifo_wr_out <= 1'b0;
			fifo_data_out <= 16'h0000;
			sync_out <= 1'b0;
			sync_prev <= 1'b0;
			wd_sample <= 9'sh000;
		end else begin
			bus_rdata_out <= rd_hit ? next_rdata : 16'h0000;
			fifo_wr_out <= (state == adsc_pkg::S_CONV) && adc_done_in && !ins_wdog;
			fifo_data_out <= {chan_mask ? {3{adc_result_in[12]}} : ptr, adc_result_in};
			sync_out <= sync_dir && conv_active;
			sync_prev <= sync_in;
			wd_sample <= adc_done_in ? $signed(adc_result_in[12:4]) : wd_sample;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Combinational outputs

	wire logic [2:0] vpos = ins0[adsc_pkg::INS_VPOS_LO +: 3];
	assign adc_ctl_out.sample = (state == adsc_pkg::S_ACQ);
	assign adc_ctl_out.start = (state == adsc_pkg::S_ACQ) && cnt_done;
	assign adc_ctl_out.res8 = ins_short;
	assign adc_ctl_out.cal_short = (state == adsc_pkg::S_CAL_SHORT) || (state == adsc_pkg::S_AZ);
	assign adc_ctl_out.cal_full = (state == adsc_pkg::S_CAL_FULL);
	assign adc_ctl_out.vin_pos = vpos;
	assign adc_ctl_out.vin_neg = ins0[adsc_pkg::INS_VNEG_LO +: 3];
	assign adc_ctl_out.route = !self_verify_mode_on ? adsc_pkg::ROUTE_NORMAL :
		(vpos == 3'h0) ? adsc_pkg::ROUTE_SELF_VERIFY_MODE_INPUTS :
		(vpos == 3'h1) ? adsc_pkg::ROUTE_SELF_VERIFY_MODE_REF : adsc_pkg::ROUTE_NORMAL;
	assign sync_oe_n_out = !sync_dir;
	assign fifo_clear_out = reset_bit;
	assign clk_gate_out = standby;
	assign flags_out = flags;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [W-1:0] state_len;
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_len <= '0;
		end else begin
			state_len <= (next_state != state || reset_bit) ? '0 : state_len + 1'b1;
		end
	end
	wire logic leaving = (next_state != state) && !reset_bit;

	acq_length_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == adsc_pkg::S_ACQ && leaving) |-> (state_len == acq_cycles - 1'b1))
		else $error("acquisition length wrong");
	short_cal_len_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == adsc_pkg::S_CAL_SHORT && leaving) |-> (state_len == W'(75))
		##1 (flags[adsc_pkg::ST_SHORT_CAL] && !short_req))
		else $error("short auto-zero length or flag wrong");
	full_cal_len_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == adsc_pkg::S_CAL_FULL && leaving) |->
		(state_len == W'(FULL_CAL_CYCLES - 1)) ##1 flags[adsc_pkg::ST_FULL_CAL])
		else $error("full calibration length or flag wrong");
	reset_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(ctrl_cmd && wval[adsc_pkg::CFG_RESET] && !wval[adsc_pkg::CFG_STANDBY] && !standby)
		##1 !ctrl_wr [*2] |-> (reset_bit && !run && ptr == 3'h0 && $past(reset_bit)) ##1 !reset_bit)
		else $error("reset bit hold wrong");
	wdog_order_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == adsc_pkg::S_CONV && adc_done_in && ins_wdog && !reset_bit) |=>
		(state == adsc_pkg::S_WD1) ##1 (state == adsc_pkg::S_WD2))
		else $error("watchdog compare order wrong");
	fifo_tag_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(fifo_wr_out && !$past(chan_mask)) |-> (fifo_data_out[15:13] == $past(ptr)))
		else $error("fifo pointer tag wrong");
	sync_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(sync_dir && $rose(adc_ctl_out.start)) |=> sync_out throughout (conv_active [*2]))
		else $error("sync output not held");
	section_guard_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(wr_hit && ram_hit && !sec_ok && !instr_end && !reset_bit) |=> $stable(ins0))
		else $error("reserved section altered memory");
	stop_after_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(instr_end && stop_pend && !ctrl_wr && !reset_bit) |=> !run && !ctrl_word[0])
		else $error("stop not honoured");

	short_cal_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
		state == adsc_pkg::S_CAL_SHORT ##1 state == adsc_pkg::S_IDLE);
	wdog_hit_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
		state == adsc_pkg::S_WD2 && hit2);
	standby_c: cover property (@(posedge sys_clk_in) disable iff (rst_in) settle_done);

endmodule

/* File: pkg/adsc_pkg.sv */
// Shared constants, types and register layout of the acquisition sequencer control
package adsc_pkg;

	// Word addresses on the parallel bus (address bits 4..1)
	localparam logic [3:0] CTRL_WADDR = 4'h8;
	localparam logic [3:0] STAT_WADDR = 4'hA;
	localparam logic [1:0] SEC_RESERVED = 2'h3;

	// Global control register bit positions
	localparam int CFG_START = 0;
	localparam int CFG_RESET = 1;
	localparam int CFG_SHORT_CAL = 2;
	localparam int CFG_FULL_CAL = 3;
	localparam int CFG_STANDBY = 4;
	localparam int CFG_CHAN_MASK = 5;
	localparam int CFG_AZ_EACH = 6;
	localparam int CFG_SYNC_OUT = 7;
	localparam int CFG_SEC_LO = 8;
	localparam int CFG_TEST = 10;
	localparam int CFG_SELF_VERIFY_MODE = 11;

	// First instruction section fields
	localparam int INS_LOOP = 0;
	localparam int INS_PAUSE = 1;
	localparam int INS_VPOS_LO = 2;
	localparam int INS_VNEG_LO = 5;
	localparam int INS_SYNC = 8;
	localparam int INS_RES8 = 10;
	localparam int INS_WDOG = 11;
	localparam int INS_ACQ_LO = 12;

	// Limit section fields
	localparam int LIM_DIR = 9;

	// Status register fields
	localparam int ST_WDOG = 0;
	localparam int ST_SHORT_CAL = 3;
	localparam int ST_FULL_CAL = 4;
	localparam int ST_PAUSE = 5;
	localparam int ST_STANDBY = 7;
	localparam int ST_PTR_LO = 8;

	// Timing, in converter clocks unless named otherwise
	localparam int unsigned CNT_W = 21;
	localparam int unsigned ACQ_BASE_12 = 9;
	localparam int unsigned ACQ_BASE_8 = 2;
	localparam int unsigned SHORT_CAL_CYC = 76;
	localparam int unsigned FULL_CAL_CYC = 4944;
	localparam logic [1:0] RESET_HOLD_CYC = 2'h2;
	localparam int unsigned CLK_FREQ_MHZ = 125;
	localparam int unsigned SETTLE_TIME_US = 10000;
	localparam int unsigned SETTLE_CYC = SETTLE_TIME_US * CLK_FREQ_MHZ;

	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_FETCH = 4'h1, S_AZ = 4'h2, S_SYNC = 4'h3, S_ACQ = 4'h4,
		S_CONV = 4'h5, S_WD1 = 4'h6, S_WD2 = 4'h7, S_CAL_SHORT = 4'h8, S_CAL_FULL = 4'h9
	} adsc_state_t;

	// Multiplexer routing in self_verify_mode
	typedef enum logic [1:0] {
		ROUTE_NORMAL = 2'h0, ROUTE_SELF_VERIFY_MODE_INPUTS = 2'h1, ROUTE_SELF_VERIFY_MODE_REF = 2'h2
	} adsc_route_t;

	// One bus cycle as seen by the device
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} adsc_bus_req_t;

	// Commands to the analog converter
	typedef struct packed {
		logic sample;
		logic start;
		logic res8;
		logic cal_short;
		logic cal_full;
		logic [2:0] vin_pos;
		logic [2:0] vin_neg;
		adsc_route_t route;
	} adsc_adc_ctl_t;

endpackage

/* File: hw/adsc_down_count.sv */
// Loadable down counter that flags the last cycle of a timed interval
`timescale 1ns/10ps
module adsc_down_count #(
	parameter int unsigned W = 21
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Control
	input wire logic load_in,
	input wire logic [W-1:0] value_in,
	// Status
	output logic busy_out,
	output logic done_out
);

	logic [W-1:0] count;

	// Interval of value_in cycles; done marks its final cycle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= '0;
		end else if (load_in) begin
			count <= value_in;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign busy_out = (count != '0);
	// Left free of load_in: the sequencer reloads on done, and a gated done would loop
	assign done_out = (count == W'(1));

endmodule

/* File: hw/adsc_limit_cmp.sv */
// Watchdog comparison of one sample against one limit section
`timescale 1ns/10ps
module adsc_limit_cmp (
	// Sample and limit
	input wire logic signed [8:0] sample_in,
	input wire logic [15:0] section_in,
	// Result
	output logic hit_out
);

	// Bits 8..0 read as a 9-bit two's complement limit, sign in bit 8
	wire logic signed [8:0] limit = $signed(section_in[8:0]);
	wire logic above_mode = section_in[adsc_pkg::LIM_DIR];

	assign hit_out = above_mode ? (sample_in > limit) : (sample_in < limit);

endmodule

/* File: verif/adsc_adc_model.sv */
// Behavioural converter that answers every start pulse after a fixed delay
`timescale 1ns/10ps
module adsc_adc_model #(
	parameter int LAT = 5,
	parameter logic [12:0] RES = 13'h1123
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Converter control
	input wire adsc_pkg::adsc_adc_ctl_t ctl_in,
	// Result
	output logic done_out,
	output logic [12:0] result_out
);
	int cnt;
	// Delay from start to done, as a real converter would need
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 0;
		end else if (ctl_in.start) begin
			cnt <= LAT;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	// Result is scrambled outside the done cycle so stale use shows up
	assign done_out = (cnt == 1);
	assign result_out = done_out ? RES : ~RES;
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the sequencer control block
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t got %h exp %h", $time, a, b); end end
module tb;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	adsc_pkg::adsc_bus_req_t req = '0;
	adsc_pkg::adsc_adc_ctl_t ctl;
	adsc_pkg::adsc_route_t rt;
	logic [15:0] rdata, fifo_data, fifo_last;
	logic [12:0] result;
	logic [7:0] flags;
	logic done, fifo_wr, fifo_clr, sync_o, sync_oe_n, clk_gate;
	logic sync_pin = 1'b0, bw = 1'b0, hi_byte = 1'b0;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	int smp_n, azs_n, azf_n, clr_n, sync_n, fifo_n;

	////////////////////////////////////////////////////////////////
	// Long counts shortened so the run stays brief
	adsc_ctrl #(.FULL_CAL_CYCLES(40), .SETTLE_CYCLES(20)) u_dut (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_req_in(req),
		.bus_width_select_in(bw), .bus_rdata_out(rdata), .adc_ctl_out(ctl),
		.adc_done_in(done), .adc_result_in(result), .fifo_wr_out(fifo_wr),
		.fifo_data_out(fifo_data), .fifo_clear_out(fifo_clr), .sync_in(sync_pin),
		.sync_out(sync_o), .sync_oe_n_out(sync_oe_n), .clk_gate_out(clk_gate),
		.flags_out(flags));
	adsc_adc_model u_adc (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ctl_in(ctl),
		.done_out(done), .result_out(result));

	// Clock of 8 ns
	initial begin
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// Activity counters; the cycle ceiling cuts a hang short
	always @(posedge sys_clk_in) begin
		cyc++;
		smp_n += ctl.sample;
		azs_n += ctl.cal_short;
		azf_n += ctl.cal_full;
		clr_n += fifo_clr;
		sync_n += sync_o;
		if (ctl.start) rt = ctl.route;
		if (fifo_wr) begin
			fifo_n++;
			fifo_last = fifo_data;
		end
		if (cyc == 6000) begin
			error_cnt++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus tasks: request set at a falling edge, held over one rising edge
	// In 8-bit mode hi_byte selects the byte lane of the word
	task automatic wr(input logic [3:0] wa, input logic [15:0] d);
		@(negedge sys_clk_in);
		req = '{1'b1, 1'b0, 1'b1, {wa, hi_byte}, d};
		@(negedge sys_clk_in);
		req = '0;
	endtask

	task automatic chk_rd(input logic [3:0] wa, input logic [15:0] exp);
		@(negedge sys_clk_in);
		req = '{1'b1, 1'b1, 1'b0, {wa, hi_byte}, 16'h0000};
		@(negedge sys_clk_in);
		req = '0;
		`CHK(rdata, exp)
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	task automatic zero(input string s);
		$display("test %s done", s);
		{smp_n, azs_n, azf_n, clr_n, sync_n, fifo_n} = '0;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (10) @(negedge sys_clk_in);
		rst_in = 1'b0;
		idle(4);
		chk_rd(4'h8, 16'h0000);
		// Every section value, the reserved one last so it must not spill
		for (int s = 0; s < 4; s++) begin
			wr(4'h8, {6'h00, 2'(s), 8'h00});
			wr(4'h0, 16'(16'h1111 * (s + 1)));
		end
		for (int s = 0; s < 4; s++) begin
			wr(4'h8, {6'h00, 2'(s), 8'h00});
			chk_rd(4'h0, (s == 3) ? 16'h0000 : 16'(16'h1111 * (s + 1)));
		end
		wr(4'h8, 16'h0000);
		wr(4'h0, 16'h1000);
		wr(4'h1, 16'h0002);
		wr(4'h8, 16'h0080);
		`CHK(sync_oe_n, 1'b0)
		chk_rd(4'h8, 16'h0080);
		chk_rd(4'h9, 16'h0000);
		zero("setup");
		wr(4'h8, 16'h0001);
		idle(60);
		`CHK(smp_n, 11)
		`CHK(fifo_last, 16'h1123)
		`CHK(rt, adsc_pkg::ROUTE_NORMAL)
		chk_rd(4'h8, 16'h0000);
		chk_rd(4'hA, 16'h0220);
		zero("run");
		wr(4'h8, 16'h0004);
		idle(100);
		`CHK(azs_n, 76)
		chk_rd(4'h8, 16'h0000);
		chk_rd(4'hA, 16'h0208);
		zero("short cal");
		wr(4'h8, 16'h0008);
		idle(60);
		`CHK(azf_n, 40)
		`CHK(flags[4], 1'b1)
		zero("full cal");
		wr(4'h8, 16'h0002);
		idle(4);
		`CHK(clr_n, 2)
		chk_rd(4'hA, 16'h0000);
		zero("reset");
		wr(4'h8, 16'h0010);
		`CHK(clk_gate, 1'b1)
		wr(4'h3, 16'h5A5A);
		chk_rd(4'h3, 16'h5A5A);
		chk_rd(4'h8, 16'h0012);
		wr(4'h8, 16'h0000);
		idle(40);
		`CHK(clk_gate, 1'b0)
		chk_rd(4'hA, 16'h0080);
		zero("standby");
		// Diagnostic, auto-zero each, mask and sync output in one run
		wr(4'h8, 16'h08E1);
		idle(150);
		`CHK(azs_n, 76)
		`CHK(smp_n, 11)
		`CHK(fifo_last, 16'hF123)
		`CHK(sync_n, 16)
		`CHK(sync_oe_n, 1'b0)
		`CHK(rt, adsc_pkg::ROUTE_SELF_VERIFY_MODE_INPUTS)
		chk_rd(4'hA, 16'h0220);
		zero("self_verify_mode run");
		// Watchdog at entry 2 waits for sync; entry 4 is a second watchdog, 5 pauses
		wr(4'h8, 16'h0000);
		`CHK(sync_oe_n, 1'b1)
		wr(4'h2, 16'h0900);
		wr(4'h4, 16'h0800);
		wr(4'h5, 16'h0002);
		wr(4'h8, 16'h0100);
		wr(4'h2, 16'h0200);
		wr(4'h4, 16'h0200);
		wr(4'h8, 16'h0200);
		wr(4'h2, 16'h0000);
		wr(4'h4, 16'h0200);
		wr(4'h8, 16'h0001);
		idle(10);
		`CHK(smp_n, 0)
		sync_pin = 1'b1;
		idle(30);
		`CHK(smp_n, 2)
		`CHK(fifo_n, 0)
		chk_rd(4'hA, 16'h0421);
		zero("watchdog");
		// Stop requested mid-instruction; both limits above the sample miss
		wr(4'h8, 16'h0001);
		wr(4'h8, 16'h0000);
		idle(30);
		`CHK(smp_n, 2)
		chk_rd(4'h8, 16'h0000);
		chk_rd(4'hA, 16'h0500);
		zero("stop request");
		// Byte-wide bus: high byte sets the section pointer, low byte merges
		bw = 1'b1;
		hi_byte = 1'b1;
		wr(4'h8, 16'h0002);
		chk_rd(4'h8, 16'h0002);
		hi_byte = 1'b0;
		chk_rd(4'h8, 16'h0000);
		wr(4'h5, 16'h005A);
		chk_rd(4'h5, 16'h005A);
		zero("byte bus");
		final_report();
	end
endmodule
